// >>> idm_blank_timer.sv
// idm_blank_timer: restartable down counter giving the blanking interval.
// assumes start is a one-cycle pulse; done is a one-cycle pulse at expiry.
module idm_blank_timer
   import idm_pkg::*;
#(
   parameter int WIDTH = IDM_BLANK_WIDTH,
   parameter logic [WIDTH-1:0] CYCLES = WIDTH'(IDM_BLANK_CYCLES)
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   output logic done
);
   logic [WIDTH-1:0] count_reg;
   logic running_reg;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         count_reg <= '0;
         running_reg <= 1'b0;
      end else if (start) begin
         count_reg <= CYCLES;
         running_reg <= 1'b1;
      end else if (running_reg) begin
         count_reg <= count_reg - WIDTH'(1);
         if (count_reg <= WIDTH'(1)) begin
            running_reg <= 1'b0;
         end
      end
   end

   assign done = running_reg && !start && (count_reg <= WIDTH'(1));
endmodule

// >>> idm_control.sv
// idm_control: gate decision for the power switch with operational assist and
// overtemperature diode emulation state machines.
// assumes gate_cmd is synchronous; drain polarity and current inputs are not.
//
// Function
// - falling command in commanded state: go forced off
// - first state waits positive drain, then second
// - second state off until negative drain
// - assist starts in second state after reset/shutdown
// - third state on; forward current goes fourth
// - fourth state locked off until command high
// - high command forces commanded-on fifth state
// - at most one assist turn-on per cycle
// - assist feature selectable present or absent
// - shutdown: command falling edge starts blanking state
// - blanking expiry advances without voltage condition
// - shutdown entry starts in off waiting state
// - negative drain moves shutdown machine to conduct
// - conduct state on; forward current returns off
// - without commands, alternate second/third states unlimited
// - error output asserted during switch shutdown
// - diode emulation inactive during driver shutdown
// - error low while either shutdown persists
module idm_control
   import idm_pkg::*;
#(
   parameter bit ASSIST_PRESENT = 1'b1,
   parameter int BLANK_CYCLES = IDM_BLANK_CYCLES
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic gate_cmd,
   input wire logic drain_positive,
   input wire logic drain_negative,
   input wire logic current_forward,
   input wire logic switch_overtemp,
   input wire logic driver_overtemp,
   output logic gate_on,
   output logic error_n
);
   // ----------------------------------------
   // input conditioning
   // ----------------------------------------
   logic pos_s;
   logic neg_s;
   logic fwd_s;
   logic cmd_prev_reg;
   logic cmd_fall;
   logic blank_done;
   logic ts_active;
   logic ts_active_prev_reg;
   logic ts_entry;
   logic blank_start;

   idm_sync u_sync_pos (.clock(clock), .reset_n(reset_n), .async_in(drain_positive), .sync_out(pos_s));
   idm_sync u_sync_neg (.clock(clock), .reset_n(reset_n), .async_in(drain_negative), .sync_out(neg_s));
   idm_sync u_sync_fwd (.clock(clock), .reset_n(reset_n), .async_in(current_forward), .sync_out(fwd_s));

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cmd_prev_reg <= 1'b0;
      end else begin
         cmd_prev_reg <= gate_cmd;
      end
   end

   assign cmd_fall = cmd_prev_reg && !gate_cmd;
   // driver shutdown overrides diode emulation entirely
   assign ts_active = switch_overtemp && !driver_overtemp;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ts_active_prev_reg <= 1'b0;
      end else begin
         ts_active_prev_reg <= ts_active;
      end
   end

   assign ts_entry = ts_active && !ts_active_prev_reg;
   assign blank_start = ts_active && cmd_fall;

   idm_blank_timer #(
      .WIDTH(IDM_BLANK_WIDTH),
      .CYCLES(IDM_BLANK_WIDTH'(BLANK_CYCLES))
   ) u_blank (
      .clock(clock),
      .reset_n(reset_n),
      .start(blank_start),
      .done(blank_done)
   );

   // ----------------------------------------
   // operational assist machine
   // ----------------------------------------
   idm_op_state_t op_reg;
   idm_op_state_t op_next;

   always_comb begin
      op_next = op_reg;
      if (gate_cmd) begin
         op_next = IDM_OP_COMMANDED;
      end else begin
         unique case (op_reg)
            IDM_OP_COMMANDED: op_next = IDM_OP_WAIT_POS;
            IDM_OP_WAIT_POS: if (pos_s) op_next = IDM_OP_WAIT_NEG;
            IDM_OP_WAIT_NEG: if (neg_s) op_next = IDM_OP_ASSIST_ON;
            IDM_OP_ASSIST_ON: if (fwd_s) op_next = IDM_OP_LOCK_OFF;
            IDM_OP_LOCK_OFF: op_next = IDM_OP_LOCK_OFF;
            default: op_next = IDM_OP_WAIT_NEG;
         endcase
      end
   end

   // any shutdown holds the machine at its start state until it clears
   always_ff @(posedge clock) begin
      if (!reset_n || switch_overtemp || driver_overtemp) begin
         op_reg <= IDM_OP_WAIT_NEG;
      end else begin
         op_reg <= op_next;
      end
   end

   // ----------------------------------------
   // shutdown diode emulation machine
   // ----------------------------------------
   idm_ts_state_t ts_reg;
   idm_ts_state_t ts_next;

   always_comb begin
      ts_next = ts_reg;
      if (cmd_fall) begin
         ts_next = IDM_TS_BLANK;
      end else begin
         unique case (ts_reg)
            IDM_TS_BLANK: if (blank_done) ts_next = IDM_TS_WAIT_NEG;
            IDM_TS_WAIT_NEG: if (neg_s) ts_next = IDM_TS_CONDUCT;
            IDM_TS_CONDUCT: if (fwd_s) ts_next = IDM_TS_WAIT_NEG;
            default: ts_next = IDM_TS_WAIT_NEG;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n || !ts_active || ts_entry) begin
         ts_reg <= IDM_TS_WAIT_NEG;
      end else begin
         ts_reg <= ts_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   logic gate_next;

   always_comb begin
      gate_next = 1'b0;
      if (driver_overtemp) begin
         gate_next = 1'b0;
      end else if (switch_overtemp) begin
         gate_next = ts_active_prev_reg && (ts_reg == IDM_TS_CONDUCT);
      end else if (ASSIST_PRESENT) begin
         gate_next = (op_reg == IDM_OP_COMMANDED) || (op_reg == IDM_OP_ASSIST_ON);
      end else begin
         gate_next = cmd_prev_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         gate_on <= 1'b0;
         error_n <= 1'b1;
      end else begin
         gate_on <= gate_next;
         error_n <= !(switch_overtemp || driver_overtemp);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_FALL_TO_FORCED_OFF: assert property (@(posedge clock) disable iff (!reset_n)
      (op_reg == IDM_OP_COMMANDED && !gate_cmd && !switch_overtemp && !driver_overtemp)
      |=> op_reg == IDM_OP_WAIT_POS)
      else $error("assist did not enter forced off on falling command");
   AST_POS_ADVANCE: assert property (@(posedge clock) disable iff (!reset_n)
      (op_reg == IDM_OP_WAIT_POS && !gate_cmd && !switch_overtemp && !driver_overtemp)
      |=> op_reg == ($past(pos_s) ? IDM_OP_WAIT_NEG : IDM_OP_WAIT_POS))
      else $error("assist positive drain advance wrong");
   AST_NEG_ADVANCE: assert property (@(posedge clock) disable iff (!reset_n)
      (op_reg == IDM_OP_WAIT_NEG && neg_s && !gate_cmd && !switch_overtemp && !driver_overtemp)
      |=> op_reg == IDM_OP_ASSIST_ON)
      else $error("assist missed negative drain");
   AST_SHUTDOWN_START: assert property (@(posedge clock) disable iff (!reset_n)
      (switch_overtemp || driver_overtemp) |=> op_reg == IDM_OP_WAIT_NEG)
      else $error("assist not parked during shutdown");
   AST_LOCK_HOLDS: assert property (@(posedge clock) disable iff (!reset_n)
      (op_reg == IDM_OP_LOCK_OFF && !gate_cmd && !switch_overtemp && !driver_overtemp)
      |=> op_reg == IDM_OP_LOCK_OFF ##1 !(ASSIST_PRESENT && gate_on && !cmd_prev_reg && !switch_overtemp))
      else $error("lock off state released early");
   AST_CMD_HIGH: assert property (@(posedge clock) disable iff (!reset_n)
      (gate_cmd && !switch_overtemp && !driver_overtemp) |=> op_reg == IDM_OP_COMMANDED)
      else $error("high command not commanded state");
   AST_TS_BLANK: assert property (@(posedge clock) disable iff (!reset_n)
      (ts_active && ts_active_prev_reg && cmd_fall) |=> ts_reg == IDM_TS_BLANK)
      else $error("falling edge did not start blanking");
   AST_TS_CONDUCT_GATE: assert property (@(posedge clock) disable iff (!reset_n)
      (ts_reg == IDM_TS_CONDUCT && ts_active && ts_active_prev_reg) |=> gate_on)
      else $error("conduct state left switch off");
   AST_ERROR_LOW: assert property (@(posedge clock) disable iff (!reset_n)
      (switch_overtemp || driver_overtemp) |=> !error_n)
      else $error("error output not low in shutdown");
   AST_DRIVER_OFF: assert property (@(posedge clock) disable iff (!reset_n)
      driver_overtemp |=> !gate_on)
      else $error("switch on during driver shutdown");

   // ----------------------------------------
   // assist output checks
   // ----------------------------------------
   AST_WAIT_POS_OFF: assert property (@(posedge clock) disable iff (!reset_n)
      (ASSIST_PRESENT && op_reg == IDM_OP_WAIT_POS && !switch_overtemp && !driver_overtemp) |=> !gate_on)
      else $error("switch on while waiting for positive drain");

   AST_WAIT_NEG_OFF: assert property (@(posedge clock) disable iff (!reset_n)
      (ASSIST_PRESENT && op_reg == IDM_OP_WAIT_NEG && !switch_overtemp && !driver_overtemp) |=> !gate_on)
      else $error("switch on while waiting for negative drain");

   AST_ASSIST_GATE_ON: assert property (@(posedge clock) disable iff (!reset_n)
      (ASSIST_PRESENT && op_reg == IDM_OP_ASSIST_ON && !switch_overtemp && !driver_overtemp) |=> gate_on)
      else $error("assist state left switch off");

   AST_FWD_LOCK: assert property (@(posedge clock) disable iff (!reset_n)
      (op_reg == IDM_OP_ASSIST_ON && fwd_s && !gate_cmd && !switch_overtemp && !driver_overtemp)
      |=> op_reg == IDM_OP_LOCK_OFF)
      else $error("forward current did not lock assist off");

   AST_LOCK_GATE_OFF: assert property (@(posedge clock) disable iff (!reset_n)
      (ASSIST_PRESENT && op_reg == IDM_OP_LOCK_OFF && !switch_overtemp && !driver_overtemp) |=> !gate_on)
      else $error("switch on in lock off state");

   AST_ONE_ASSIST: assert property (@(posedge clock) disable iff (!reset_n)
      (op_reg == IDM_OP_LOCK_OFF && !gate_cmd && !switch_overtemp && !driver_overtemp)
      |=> op_reg != IDM_OP_ASSIST_ON)
      else $error("second assist turn-on in one command cycle");

   AST_BARE_FOLLOWS: assert property (@(posedge clock) disable iff (!reset_n)
      (!ASSIST_PRESENT && !switch_overtemp && !driver_overtemp) |=> gate_on == $past(cmd_prev_reg))
      else $error("switch without assist does not follow command");

   // ----------------------------------------
   // shutdown machine checks
   // ----------------------------------------
   AST_BLANK_OFF: assert property (@(posedge clock) disable iff (!reset_n)
      (ts_reg == IDM_TS_BLANK && switch_overtemp && !driver_overtemp) |=> !gate_on)
      else $error("switch on during blanking");

   AST_BLANK_EXPIRE: assert property (@(posedge clock) disable iff (!reset_n)
      (ts_reg == IDM_TS_BLANK && blank_done && !cmd_fall && ts_active && !ts_entry)
      |=> ts_reg == IDM_TS_WAIT_NEG)
      else $error("blanking expiry did not advance");

   AST_TS_ENTRY: assert property (@(posedge clock) disable iff (!reset_n)
      ts_entry |=> ts_reg == IDM_TS_WAIT_NEG)
      else $error("shutdown entry not in waiting state");

   AST_TS_WAIT_OFF: assert property (@(posedge clock) disable iff (!reset_n)
      (ts_reg == IDM_TS_WAIT_NEG && switch_overtemp && !driver_overtemp) |=> !gate_on)
      else $error("switch on in shutdown waiting state");

   AST_TS_NEG: assert property (@(posedge clock) disable iff (!reset_n)
      (ts_reg == IDM_TS_WAIT_NEG && neg_s && ts_active && !ts_entry && !cmd_fall)
      |=> ts_reg == IDM_TS_CONDUCT)
      else $error("negative drain did not start conduction");

   AST_TS_FWD: assert property (@(posedge clock) disable iff (!reset_n)
      (ts_reg == IDM_TS_CONDUCT && fwd_s && ts_active && !ts_entry && !cmd_fall)
      |=> ts_reg == IDM_TS_WAIT_NEG)
      else $error("forward current did not end conduction");

   AST_TS_PAIR: assert property (@(posedge clock) disable iff (!reset_n)
      (ts_active && !ts_entry && !cmd_fall && ts_reg != IDM_TS_BLANK) |=> ts_reg != IDM_TS_BLANK)
      else $error("blanking entered without a command edge");

   AST_SW_ERROR: assert property (@(posedge clock) disable iff (!reset_n)
      switch_overtemp |=> !error_n)
      else $error("error output high in switch shutdown");

   AST_TS_IDLE_DRIVER: assert property (@(posedge clock) disable iff (!reset_n)
      driver_overtemp |=> ts_reg == IDM_TS_WAIT_NEG)
      else $error("diode emulation active in driver shutdown");

   AST_ERROR_HIGH: assert property (@(posedge clock) disable iff (!reset_n)
      (!switch_overtemp && !driver_overtemp) |=> error_n)
      else $error("error output low without shutdown");
endmodule

// >>> idm_ctrl_model.sv
// idm_ctrl_model: behavioural supply controller that makes gate command pulses.
// assumes requests arrive at the falling edge of clock; cmd_len is never zero.
module idm_ctrl_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cmd_req,
   input wire logic [3:0] cmd_len,
   output logic gate_cmd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left_reg;
   // falling-edge updates keep the level settled at the device's sampling edge
   always @(negedge clock) begin
      if (!reset_n) begin
         gate_cmd <= 1'b0;
         left_reg <= 4'h0;
      end else if (left_reg != 4'h0) begin
         left_reg <= left_reg - 4'h1;
         if (left_reg == 4'h1) begin
            gate_cmd <= 1'b0;
         end
      end else if (cmd_req) begin
         gate_cmd <= 1'b1;
         left_reg <= cmd_len;
      end
   end
endmodule

// >>> idm_pkg.sv
// idm_pkg: shared constants and state types for the ideal diode mode control.
// assumes one 10 MHz system clock shared by every module of the block.
package idm_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int IDM_CLOCK_HZ = 10000000;
   localparam int IDM_BLANK_NS = 200;
   localparam int IDM_BLANK_CYCLES = (IDM_BLANK_NS * (IDM_CLOCK_HZ / 1000000) + 999) / 1000;
   localparam int IDM_SYNC_STAGES = 2;
   localparam int IDM_BLANK_WIDTH = 16;
   // ----------------------------------------
   // states
   // ----------------------------------------
   typedef enum logic [2:0] {
      IDM_OP_WAIT_POS,
      IDM_OP_WAIT_NEG,
      IDM_OP_ASSIST_ON,
      IDM_OP_LOCK_OFF,
      IDM_OP_COMMANDED
   } idm_op_state_t;
   typedef enum logic [1:0] {
      IDM_TS_BLANK,
      IDM_TS_WAIT_NEG,
      IDM_TS_CONDUCT
   } idm_ts_state_t;
endpackage

// >>> idm_sync.sv
// idm_sync: multi-stage level synchroniser for one sensed polarity input.
// assumes the input may change at any time relative to clock.
module idm_sync
   import idm_pkg::*;
#(
   parameter int STAGES = IDM_SYNC_STAGES
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic async_in,
   output logic sync_out
);
   logic [STAGES-1:0] chain_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         chain_reg <= '0;
      end else begin
         chain_reg <= {chain_reg[STAGES-2:0], async_in};
      end
   end

   assign sync_out = chain_reg[STAGES-1];
endmodule

// >>> tb_ideal_diode_mode_control.sv
// tb_ideal_diode_mode_control: self-checking bench, one instance with and one without the assist.
// assumes a 10 MHz clock and the controller model in idm_ctrl_model.
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fails++; $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module tb_ideal_diode_mode_control;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BLANK = 8;
   localparam int LIMIT = 5000;
   logic clock = 1'b0;
   logic reset_n, drain_positive, drain_negative, current_forward, switch_overtemp, driver_overtemp, cmd_req;
   logic [3:0] cmd_len;
   logic gate_cmd, gate_on, error_n, gate_on_bare, error_n_bare, pos;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   idm_ctrl_model idm_ctrl_model_inst (.clock(clock), .reset_n(reset_n), .cmd_req(cmd_req), .cmd_len(cmd_len),
      .gate_cmd(gate_cmd));
   idm_control #(.ASSIST_PRESENT(1'b1), .BLANK_CYCLES(BLANK)) idm_control_inst (.clock(clock), .reset_n(reset_n),
      .gate_cmd(gate_cmd), .drain_positive(drain_positive), .drain_negative(drain_negative),
      .current_forward(current_forward), .switch_overtemp(switch_overtemp), .driver_overtemp(driver_overtemp),
      .gate_on(gate_on), .error_n(error_n));
   idm_control #(.ASSIST_PRESENT(1'b0), .BLANK_CYCLES(BLANK)) idm_control_noassist_inst (.clock(clock),
      .reset_n(reset_n), .gate_cmd(gate_cmd), .drain_positive(drain_positive), .drain_negative(drain_negative),
      .current_forward(current_forward), .switch_overtemp(switch_overtemp), .driver_overtemp(driver_overtemp),
      .gate_on(gate_on_bare), .error_n(error_n_bare));
   always #50 clock = ~clock;
   function automatic logic exp_assist(input logic pos_seen);
      return pos_seen;
   endfunction
   function automatic logic exp_error(input logic sw, input logic drv);
      return !(sw || drv);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   // six cycles cover the synchroniser, the state step and the registered gate
   task automatic sense(input logic p, input logic n, input logic f);
      @(negedge clock);
      drain_positive <= p;
      drain_negative <= n;
      current_forward <= f;
      cyc(6);
   endtask
   task automatic pulse(input logic [3:0] len);
      @(negedge clock);
      cmd_req <= 1'b1;
      cmd_len <= len;
      @(negedge clock);
      cmd_req <= 1'b0;
   endtask
   task automatic temp(input logic sw, input logic drv);
      @(negedge clock);
      switch_overtemp <= sw;
      driver_overtemp <= drv;
      cyc(6);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // a hang ends the run as a failure instead of running forever
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails++;
         summarize();
      end
   end
   initial begin
      {reset_n, drain_positive, drain_negative, current_forward, switch_overtemp, driver_overtemp, cmd_req} = '0;
      cmd_len = 4'h1;
      void'($urandom(32'h4b9e));
      cyc(16);
      reset_n <= 1'b1;
      cyc(2);
      `CHK("error_n", exp_error(1'b0, 1'b0), error_n)
      sense(1'b0, 1'b1, 1'b0);
      `CHK("gate_on", 1'b1, gate_on)
      `CHK("gate_on_bare", 1'b0, gate_on_bare)
      sense(1'b0, 1'b0, 1'b1);
      `CHK("gate_on", 1'b0, gate_on)
      pulse(4'h8);
      cyc(4);
      `CHK("gate_on", 1'b1, gate_on)
      `CHK("gate_on_bare", 1'b1, gate_on_bare)
      cyc(8);
      `CHK("gate_on", 1'b0, gate_on)
      sense(1'b0, 1'b1, 1'b0);
      `CHK("gate_on", 1'b0, gate_on)
      $display("test startup and command done");
      for (int i = 0; i < 12; i++) begin
         cmd_len = 4'($urandom_range(8, 1));
         pulse(cmd_len);
         cyc(int'(cmd_len) + 4);
         `CHK("gate_on", 1'b0, gate_on)
         pos = 1'($urandom_range(1));
         if (pos) sense(1'b1, 1'b0, 1'b0);
         sense(1'b0, 1'b1, 1'b0);
         `CHK("gate_on", exp_assist(pos), gate_on)
         sense(1'b0, 1'b0, 1'b1);
         `CHK("gate_on", 1'b0, gate_on)
         sense(1'b0, 1'b1, 1'b0);
         `CHK("gate_on", 1'b0, gate_on)
         sense(1'b0, 1'b0, 1'b0);
      end
      $display("test random assist cycles done");
      temp(1'b1, 1'b0);
      `CHK("error_n", exp_error(1'b1, 1'b0), error_n)
      `CHK("gate_on", 1'b0, gate_on)
      repeat (2) begin
         sense(1'b0, 1'b1, 1'b0);
         `CHK("gate_on", 1'b1, gate_on)
         `CHK("gate_on_bare", 1'b1, gate_on_bare)
         sense(1'b0, 1'b0, 1'b1);
         `CHK("gate_on", 1'b0, gate_on)
      end
      sense(1'b0, 1'b1, 1'b0);
      pulse(4'h1);
      cyc(3);
      `CHK("gate_on", 1'b0, gate_on)
      cyc(12);
      `CHK("gate_on", 1'b1, gate_on)
      temp(1'b1, 1'b1);
      `CHK("gate_on", 1'b0, gate_on)
      `CHK("error_n", exp_error(1'b1, 1'b1), error_n)
      temp(1'b1, 1'b0);
      `CHK("gate_on", 1'b1, gate_on)
      temp(1'b0, 1'b1);
      `CHK("error_n", exp_error(1'b0, 1'b1), error_n)
      temp(1'b0, 1'b0);
      `CHK("error_n", exp_error(1'b0, 1'b0), error_n)
      `CHK("gate_on", 1'b1, gate_on)
      `CHK("gate_on_bare", 1'b0, gate_on_bare)
      $display("test overtemperature done");
      summarize();
   end
endmodule
